// File: hw/lcdms_pkg.sv
// Package for the LCD mode-state and timing core: offsets, reset values, counts and types.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
`default_nettype none

package lcdms_pkg;

  // ************************************************************
  // Register offsets on the plain host port.
  // ************************************************************
  localparam logic [7:0] REG_COMMAND = 8'h00;  // Write: command byte.
  localparam logic [7:0] REG_DATA = 8'h01;     // Write or read: display data at the pointer.
  localparam logic [7:0] REG_STATUS = 8'h02;   // Read: busy in bit 0, standby in bit 1.
  localparam logic [7:0] REG_MODE = 8'h03;     // Read: display and blink mode bits.
  localparam logic [7:0] REG_POINTER = 8'h04;  // Read: address pointer.
  localparam logic [7:0] REG_SETUP = 8'h05;    // Read: contrast, divider, bank, lines.

  // ************************************************************
  // Values after reset and pointer walk limits.
  // ************************************************************
  localparam logic [5:0] POINTER_RESET = 6'h00;
  localparam logic [1:0] LOAD_OPT_RESET = 2'h0;
  localparam logic [1:0] DIVIDER_RESET = 2'h0;
  localparam logic [2:0] CONTRAST_RESET = 3'h0;
  localparam logic [1:0] MARKER_LINE_RESET = 2'h0;
  localparam logic [5:0] GROUP0_LAST = 6'h0b;   // Character row one ends at 11.
  localparam logic [5:0] GROUP1_FIRST = 6'h10;  // Character row two starts at 16.
  localparam logic [5:0] GROUP1_LAST = 6'h1b;
  localparam logic [5:0] GROUP2_FIRST = 6'h20;  // Marker row one starts at 32.
  localparam logic [5:0] GROUP2_LAST = 6'h2b;
  localparam logic [5:0] GROUP3_FIRST = 6'h30;  // Marker row two starts at 48.
  localparam logic [5:0] GROUP3_LAST = 6'h3b;
  localparam logic [7:0] BLANK_CODE = 8'h20;    // Space character, used by the clear option.
  localparam logic [1:0] LOAD_OPT_BLANK = 2'h1; // Load option that blanks on pointer step.
  localparam logic [7:0] MARKER_MASK = 8'h1f;   // Only five marker dots are meaningful.

  // ************************************************************
  // Counts, in periods of the divided source clock.
  // ************************************************************
  localparam logic [8:0] FRAME_PERIODS_16 = 9'h1c0;  // 448 periods.
  localparam logic [8:0] FRAME_PERIODS_9 = 9'h1d4;   // 468 periods.
  localparam int unsigned BLINK_BITS = 15;           // Blink cycle of two to the fifteenth.
  localparam logic [3:0] BUSY_PERIODS = 4'ha;        // Ten periods of busy.

  // ************************************************************
  // Types.
  // ************************************************************
  typedef enum logic [3:0] {
    LCDMS_CMD_NONE, LCDMS_CMD_POINTER, LCDMS_CMD_LOAD_OPT, LCDMS_CMD_DIVIDER,
    LCDMS_CMD_BANK, LCDMS_CMD_CONTRAST, LCDMS_CMD_STANDBY, LCDMS_CMD_SERIAL_OUT,
    LCDMS_CMD_DISPLAY, LCDMS_CMD_STEP, LCDMS_CMD_MARKER_BLINK, LCDMS_CMD_PATTERN,
    LCDMS_CMD_MARKER_LINE, LCDMS_CMD_CHAR_BLINK
  } lcdms_cmd_t;

  // Every mode setting, carried out to the display drive logic as one bundle.
  typedef struct packed {
    logic [5:0] pointer_value;
    logic [1:0] load_opt;
    logic [1:0] divider_sel;
    logic bank;
    logic [2:0] contrast;
    logic standby;
    logic serial_out_enable;
    logic display_on;
    logic markers_only;
    logic marker_blink;
    logic blink_pattern;
    logic [1:0] marker_line;
  } lcdms_mode_t;

  // One scanned display memory location.
  typedef struct packed {
    logic [7:0] code;
    logic char_blink;
    logic [4:0] marker_blink;
  } lcdms_scan_t;

endpackage : lcdms_pkg

`default_nettype wire

// File: hw/lcdms_core.sv
// Mode-state and timing core of a dot-matrix LCD controller.
// Assumes a host on the same clock drives the plain register port with one-cycle strobes,
// and that the oscillator, duty and interface-select pins are asynchronous.
`default_nettype none

module lcdms_core
  import lcdms_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Host register port.
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // Asynchronous pins.
  input wire logic osc_in,
  input wire logic duty_nine,
  input wire logic serial_mode,
  // Serial output pin, busy flag in serial mode.
  output logic so_out,
  output logic so_oe,
  // Display scan port, from drive logic on this clock.
  input wire logic [5:0] scan_addr,
  output lcdms_scan_t scan_data,
  // Mode and timing to the drive logic.
  output lcdms_mode_t mode,
  output logic frame_pulse,
  output logic blink_phase
);

  // ************************************************************
  // Functions.
  // ************************************************************

  // Next pointer value: four groups of twelve, skipping the gaps.
  function automatic logic [5:0] step_pointer(input logic [5:0] p);
    logic [5:0] n;
    n = p + 6'h01;
    if (p == GROUP0_LAST) begin
      n = GROUP1_FIRST;
    end else if (p == GROUP1_LAST) begin
      n = GROUP2_FIRST;
    end else if (p == GROUP2_LAST) begin
      n = GROUP3_FIRST;
    end else if (p == GROUP3_LAST) begin
      n = POINTER_RESET;
    end
    return n;
  endfunction

  // True for an address that lies in one of the two marker rows.
  function automatic logic is_marker(input logic [5:0] p);
    return (p >= GROUP2_FIRST && p <= GROUP2_LAST) || (p >= GROUP3_FIRST && p <= GROUP3_LAST);
  endfunction

  // Command byte to command kind.
  function automatic lcdms_cmd_t decode_cmd(input logic [7:0] c);
    lcdms_cmd_t k;
    k = LCDMS_CMD_NONE;
    if (c[7:6] == 2'h3) begin
      k = LCDMS_CMD_POINTER;
    end else if (c[7:4] == 4'h4) begin
      k = LCDMS_CMD_LOAD_OPT;
    end else if (c[7:4] == 4'h5) begin
      k = LCDMS_CMD_DIVIDER;
    end else if (c[7:5] == 3'h3) begin
      k = LCDMS_CMD_MARKER_LINE;
    end else if (c[7:5] == 3'h0 && c[3:2] == 2'h0) begin
      k = LCDMS_CMD_CHAR_BLINK;
    end else if (c[7:5] == 3'h4) begin
      case (c[3:1])
        3'h0: k = LCDMS_CMD_BANK;
        3'h1: k = LCDMS_CMD_CONTRAST;
        3'h2: k = c[0] ? LCDMS_CMD_NONE : LCDMS_CMD_STANDBY;
        3'h3: k = LCDMS_CMD_SERIAL_OUT;
        3'h4: k = LCDMS_CMD_DISPLAY;
        3'h5: k = LCDMS_CMD_STEP;
        3'h6: k = LCDMS_CMD_MARKER_BLINK;
        default: k = LCDMS_CMD_PATTERN;
      endcase
    end
    return k;
  endfunction

  // ************************************************************
  // Access decode.
  // ************************************************************
  logic cmd_write;     // Command byte written this cycle.
  logic data_write;    // Display data byte written this cycle.
  logic data_read;     // Display data byte read this cycle.
  logic wake;          // Incoming byte has bit 0 set.
  lcdms_cmd_t cmd;     // Decoded command kind.
  logic ptr_advance;   // Pointer steps this cycle.

  assign cmd_write = write_strobe && (address == REG_COMMAND);
  assign data_write = write_strobe && (address == REG_DATA);
  assign data_read = read_strobe && (address == REG_DATA);
  assign wake = (cmd_write || data_write) && write_data[0];
  assign cmd = cmd_write ? decode_cmd(write_data) : LCDMS_CMD_NONE;
  assign ptr_advance = data_write || data_read || (cmd == LCDMS_CMD_STEP)
                       || (cmd == LCDMS_CMD_CHAR_BLINK);

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  logic [1:0] osc_sync;   // Oscillator, two stages.
  logic osc_last;         // Previous synchronised oscillator level, for the edge.
  logic [1:0] duty_sync;  // Duty select, two stages.
  logic [1:0] ser_sync;   // Interface select, two stages.

  // Only the second stage of each pair is read by logic.
  always_ff @(posedge clock) begin
    if (reset) begin
      osc_sync <= 2'h0;
      osc_last <= 1'b0;
      duty_sync <= 2'h0;
      ser_sync <= 2'h0;
    end else begin
      osc_sync <= {osc_sync[0], osc_in};
      osc_last <= osc_sync[1];
      duty_sync <= {duty_sync[0], duty_nine};
      ser_sync <= {ser_sync[0], serial_mode};
    end
  end

  // ************************************************************
  // Source clock divider.
  // ************************************************************
  logic osc_edge;          // One rising edge of the oscillator.
  logic [2:0] div_count;   // Counts oscillator edges.
  logic [2:0] div_mask;    // Low bits that must all be set for a tick.
  logic src_tick;          // One period of the divided source clock.

  assign osc_edge = osc_sync[1] && !osc_last;
  assign div_mask = 3'((4'h1 << mode.divider_sel) - 4'h1);
  // The oscillator is stopped in standby, so no timing advances there.
  assign src_tick = osc_edge && !mode.standby && ((div_count & div_mask) == div_mask);

  // Free-running edge counter; the mask picks divide by 1, 2, 4 or 8.
  always_ff @(posedge clock) begin
    if (reset) begin
      div_count <= 3'h0;
    end else if (osc_edge && !mode.standby) begin
      div_count <= div_count + 3'h1;
    end
  end

  // ************************************************************
  // Frame and blink timing.
  // ************************************************************
  logic [8:0] frame_count;      // Position inside the frame.
  logic [8:0] frame_last;       // Last count of the frame for the current duty.
  logic [BLINK_BITS-1:0] blink_count;  // Position inside the blink cycle.

  assign frame_last = duty_sync[1] ? FRAME_PERIODS_9 - 9'h1 : FRAME_PERIODS_16 - 9'h1;

  // The frame counter also catches a duty change that leaves it past the new end.
  always_ff @(posedge clock) begin
    if (reset) begin
      frame_count <= 9'h0;
      frame_pulse <= 1'b0;
    end else begin
      frame_pulse <= 1'b0;
      if (src_tick) begin
        if (frame_count >= frame_last) begin
          frame_count <= 9'h0;
          frame_pulse <= 1'b1;
        end else begin
          frame_count <= frame_count + 9'h1;
        end
      end
    end
  end

  // The blink cycle wraps naturally; its upper bit gives the on and off halves.
  always_ff @(posedge clock) begin
    if (reset) begin
      blink_count <= '0;
    end else if (src_tick) begin
      blink_count <= blink_count + 1'b1;
    end
  end
  assign blink_phase = blink_count[BLINK_BITS-1];

  // ************************************************************
  // Busy timing.
  // ************************************************************
  logic [3:0] busy_count;  // Source periods left busy.
  logic busy;              // Host must wait.

  // Each command or data access reloads the count, except the standby command, which clears it.
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_count <= 4'h0;
    end else if ((cmd_write && cmd != LCDMS_CMD_STANDBY) || data_write || data_read) begin
      busy_count <= BUSY_PERIODS;
    end else if (cmd == LCDMS_CMD_STANDBY) begin
      busy_count <= 4'h0;
    end else if (src_tick && busy_count != 4'h0) begin
      busy_count <= busy_count - 4'h1;
    end
  end
  assign busy = (busy_count != 4'h0);

  // Busy reads high on the serial pin, which floats unless enabled in serial mode.
  assign so_out = busy;
  assign so_oe = ser_sync[1] && mode.serial_out_enable;

  // ************************************************************
  // Mode settings.
  // ************************************************************

  // Pointer: loaded, stepped, or zeroed on entering standby.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode.pointer_value <= POINTER_RESET;
    end else if (cmd == LCDMS_CMD_STANDBY) begin
      mode.pointer_value <= POINTER_RESET;
    end else if (cmd == LCDMS_CMD_POINTER) begin
      mode.pointer_value <= write_data[5:0];
    end else if (ptr_advance) begin
      mode.pointer_value <= step_pointer(mode.pointer_value);
    end
  end

  // Standby: set by its command, left on any byte with bit 0 set.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode.standby <= 1'b0;
    end else if (cmd == LCDMS_CMD_STANDBY) begin
      mode.standby <= 1'b1;
    end else if (wake) begin
      mode.standby <= 1'b0;
    end
  end

  // Display switch: cleared on entering standby, like the pointer; other settings untouched there.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode.display_on <= 1'b0;
      mode.markers_only <= 1'b0;
    end else if (cmd == LCDMS_CMD_STANDBY) begin
      mode.display_on <= 1'b0;
      mode.markers_only <= 1'b0;
    end else if (cmd == LCDMS_CMD_DISPLAY) begin
      mode.display_on <= write_data[0];
      mode.markers_only <= write_data[4];
    end
  end

  // Remaining settings change only by their own commands, so standby keeps them.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode.load_opt <= LOAD_OPT_RESET;
      mode.divider_sel <= DIVIDER_RESET;
      mode.bank <= 1'b0;
      mode.serial_out_enable <= 1'b0;
      mode.marker_blink <= 1'b0;
      mode.blink_pattern <= 1'b0;
      mode.marker_line <= MARKER_LINE_RESET;
    end else begin
      case (cmd)
        LCDMS_CMD_LOAD_OPT: mode.load_opt <= write_data[1:0];
        LCDMS_CMD_DIVIDER: mode.divider_sel <= write_data[1:0];
        LCDMS_CMD_BANK: mode.bank <= write_data[0];
        LCDMS_CMD_SERIAL_OUT: mode.serial_out_enable <= write_data[0];
        LCDMS_CMD_MARKER_BLINK: mode.marker_blink <= write_data[0];
        LCDMS_CMD_PATTERN: mode.blink_pattern <= write_data[0];
        LCDMS_CMD_MARKER_LINE: mode.marker_line <= write_data[1:0];
        default: begin
        end
      endcase
    end
  end

  // Contrast: three bits, wrapping both ways.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode.contrast <= CONTRAST_RESET;
    end else if (cmd == LCDMS_CMD_CONTRAST) begin
      if (write_data[0]) begin
        mode.contrast <= mode.contrast + 3'h1;
      end else begin
        mode.contrast <= mode.contrast - 3'h1;
      end
    end
  end

  // ************************************************************
  // Display memory.
  // ************************************************************
  logic [7:0] code_ram [64];         // Character codes and marker dots.
  logic [4:0] marker_blink_ram [64]; // Marker blink enables.
  logic [63:0] char_blink_ram;       // Per-character blink enables.
  logic [7:0] data_in;               // Incoming byte with marker bits masked.

  // Marker rows keep only five dots, whatever the host sends above them.
  assign data_in = is_marker(mode.pointer_value) ? (write_data & MARKER_MASK) : write_data;

  // No reset here: contents survive reset and standby and are cleared only by writes and by the step command under the blank load option.
  always_ff @(posedge clock) begin
    if (data_write && !mode.marker_blink) begin
      code_ram[mode.pointer_value] <= data_in;
    end else if (cmd == LCDMS_CMD_STEP && mode.load_opt == LOAD_OPT_BLANK) begin
      code_ram[mode.pointer_value] <= BLANK_CODE;
    end
  end

  // Blink data is only accepted for marker rows; other addresses ignore it.
  always_ff @(posedge clock) begin
    if (data_write && mode.marker_blink && is_marker(mode.pointer_value)) begin
      marker_blink_ram[mode.pointer_value] <= write_data[4:0];
    end
  end

  // Character blink enables, set per address by their command.
  always_ff @(posedge clock) begin
    if (cmd == LCDMS_CMD_CHAR_BLINK) begin
      char_blink_ram[mode.pointer_value] <= write_data[1];
    end
  end

  // Scan port output, registered for the drive logic.
  always_ff @(posedge clock) begin
    if (reset) begin
      scan_data <= '0;
    end else begin
      scan_data.code <= code_ram[scan_addr];
      scan_data.char_blink <= char_blink_ram[scan_addr];
      scan_data.marker_blink <= marker_blink_ram[scan_addr];
    end
  end

  // ************************************************************
  // Register read-back.
  // ************************************************************

  // Data appear in the cycle after the strobe only; unmapped offsets read zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      if (address == REG_DATA) begin
        read_data <= code_ram[mode.pointer_value];
      end else if (address == REG_STATUS) begin
        read_data <= {6'h00, mode.standby, busy};
      end else if (address == REG_MODE) begin
        read_data <= {3'h0, mode.blink_pattern, mode.marker_blink, mode.markers_only,
                      mode.display_on, mode.serial_out_enable};
      end else if (address == REG_POINTER) begin
        read_data <= {2'h0, mode.pointer_value};
      end else if (address == REG_SETUP) begin
        read_data <= {mode.contrast, mode.divider_sel, mode.bank, mode.marker_line};
      end else begin
        read_data <= 8'h00;
      end
    end else begin
      read_data <= 8'h00;
    end
  end

endmodule : lcdms_core

`default_nettype wire

// File: test/lcdms_core_chk.sv
// Checker for the LCD mode core: reset values, standby, busy and pointer relations.
// Assumes one clock, the synchronous reset, and an oscillator of four clocks per period.
`default_nettype none
module lcdms_core_chk
  import lcdms_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Host port.
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  // Watched outputs.
  input wire logic so_out,
  input wire logic so_oe,
  input wire lcdms_mode_t mode,
  input wire logic frame_pulse,
  input wire logic blink_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ten ticks at divide-by-eight plus sync slack; only valid for the bench oscillator rate.
  localparam int BUSY_MAX = 400;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ********
  // Assertions.
  // ********
  // One command byte accepted at the port.
  sequence s_cmd(logic [7:0] c);
    write_strobe && address == REG_COMMAND && write_data == c;
  endsequence
  chk_reset_mode: assert property (disable iff (1'b0) reset |=> mode == '0)
    else $error("mode bits not at defaults after reset");
  chk_reset_pins: assert property (disable iff (1'b0) reset |=> !so_oe && !blink_phase)
    else $error("serial output or blink not idle after reset");
  chk_standby_entry: assert property (s_cmd(8'h84) |=> mode.standby &&
    mode.pointer_value == 6'h00 && !mode.display_on && !mode.markers_only)
    else $error("standby entry did not clear pointer and display");
  chk_standby_keeps: assert property (s_cmd(8'h84) |=> $stable({mode.load_opt,
    mode.divider_sel, mode.bank, mode.contrast, mode.serial_out_enable, mode.marker_line}))
    else $error("standby entry changed a kept setting");
  chk_wake_byte: assert property (mode.standby && write_strobe &&
    address <= REG_DATA && write_data[0] |=> !mode.standby)
    else $error("byte with bit zero set did not end standby");
  chk_busy_raise: assert property (write_strobe && address <= REG_DATA &&
    !(address == REG_COMMAND && write_data[7:5] == 3'h4 && write_data[3:0] == 4'h4) |=> so_out)
    else $error("busy not raised after an access");
  chk_busy_ends: assert property ($rose(so_out) |-> ##[1:BUSY_MAX] !so_out)
    else $error("busy lasted too long");
  chk_contrast_step: assert property (s_cmd(8'h83) |=>
    mode.contrast == $past(mode.contrast) + 3'h1)
    else $error("contrast did not step up by one");
  chk_pointer_skip: assert property (write_strobe && address == REG_DATA &&
    !mode.standby && !mode.marker_blink && mode.pointer_value == 6'h0b |=>
    mode.pointer_value == 6'h10)
    else $error("pointer did not skip from 11 to 16");
  chk_frame_single: assert property (frame_pulse |=> !frame_pulse)
    else $error("frame pulse lasted more than one cycle");
endmodule // lcdms_core_chk
bind lcdms_core lcdms_core_chk i_lcdms_core_chk (.clock(clock), .reset(reset),
  .address(address), .write_data(write_data), .write_strobe(write_strobe), .so_out(so_out),
  .so_oe(so_oe), .mode(mode), .frame_pulse(frame_pulse), .blink_phase(blink_phase));
`default_nettype wire

// File: test/lcdms_osc_model.sv
// Oscillator source standing in for the crystal on the core's oscillator pin.
// Assumes the core synchronises the pin, so no phase tie to the system clock is needed.
`default_nettype none
module lcdms_osc_model #(
  parameter int HALF_NS = 100  // Half period; a larger value gives a slower source.
) (
  // Oscillator pin.
  output logic osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The crystal runs free; the odd offset keeps edges clear of system clock edges.
  initial begin
    osc_in = 1'b0;
    #37;
    forever #(HALF_NS) osc_in = ~osc_in;
  end
endmodule // lcdms_osc_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the LCD mode core: host accesses, standby, memory and timing.
// Assumes the oscillator model on the oscillator pin and the checker bound to the core.
`default_nettype none
module testbench
  import lcdms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC = 4;  // System clocks per oscillator period.
  logic clock = 1'b0, reset = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0, osc_q = 1'b0;
  logic duty_nine = 1'b0, serial_mode = 1'b0, osc_in, so_out, so_oe, frame_pulse, blink_phase;
  logic [7:0] address = 8'h00, write_data = 8'h00, read_data, v;
  logic [5:0] scan_addr = 6'h00;
  lcdms_scan_t scan_data;
  lcdms_mode_t mode;
  int n_mismatch = 0, total_checks = 0, cycles = 0, ticks = 0, n, t0, ta, tb;
  // Contrast is set before the display goes on, as a careful host does.
  logic [7:0] setup_cmds [8] = '{8'h83, 8'h83, 8'h81, 8'h87, 8'h99, 8'h8f, 8'h63, 8'hc5};
  always #25 clock = ~clock;
  // Count source edges and cut a hang short.
  always @(posedge clock) begin
    osc_q <= osc_in;
    if (osc_in && !osc_q) ticks <= ticks + 1;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      summarize();
    end
  end
  lcdms_osc_model i_lcdms_osc_model (.osc_in(osc_in));
  lcdms_core i_lcdms_core (.clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .osc_in(osc_in), .duty_nine(duty_nine), .serial_mode(serial_mode),
    .so_out(so_out), .so_oe(so_oe), .scan_addr(scan_addr), .scan_data(scan_data), .mode(mode),
    .frame_pulse(frame_pulse), .blink_phase(blink_phase));
  // ********
  // Tasks.
  // ********
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkn(string nm, int e, int g);
    total_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk8(nm, e, read_data);
  endtask
  // Wait, under a bound, until busy drops; n holds the busy length in clocks.
  task automatic pace();
    #1 n = 0;
    while (so_out !== 1'b0 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    // A busy flag that never drops is a failure, not a silent pass.
    if (so_out !== 1'b0) n_mismatch++;
  endtask
  task automatic put(logic [7:0] a, logic [7:0] d);
    wr(a, d);
    pace();
  endtask
  task automatic scan(logic [5:0] a, logic [7:0] e);
    @(posedge clock);
    scan_addr <= a;
    @(posedge clock);
    #1 chk8("scan_code", e, scan_data.code);
  endtask
  task automatic wpulse(output int t);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (frame_pulse !== 1'b1 && n < 20000);
    if (frame_pulse !== 1'b1) n_mismatch++;
    t = ticks;
  endtask
  // ********
  // Main sequence.
  // ********
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rchk("mode", REG_MODE, 8'h00);
    rchk("pointer", REG_POINTER, 8'h00);
    rchk("setup", REG_SETUP, 8'h00);
    rchk("status", REG_STATUS, 8'h00);
    rchk("unmapped", 8'h3f, 8'h00);
    chk8("so_oe", 8'h00, {7'h00, so_oe});
    // Busy length scales with every divider code.
    for (int d = 3; d >= 0; d--) begin
      put(REG_COMMAND, 8'h50 | 8'(d));
      chkn("busy_len", 1, int'(n > (9 << d) * OSC - 4 && n <= (10 << d) * OSC + 8));
    end
    wr(REG_COMMAND, 8'h50);
    rchk("status_busy", REG_STATUS, 8'h01);
    pace();
    put(REG_COMMAND, 8'hcb);
    put(REG_DATA, 8'h41);
    rchk("pointer_skip", REG_POINTER, 8'h10);
    put(REG_COMMAND, 8'hfb);
    put(REG_DATA, 8'h5a);
    rchk("pointer_wrap", REG_POINTER, 8'h00);
    put(REG_COMMAND, 8'he0);
    put(REG_DATA, 8'hff);
    put(REG_COMMAND, 8'he0);
    put(REG_COMMAND, 8'h8d);
    put(REG_DATA, 8'hf5);
    put(REG_COMMAND, 8'h8c);
    scan(6'h20, 8'h1f);
    chk8("scan_blink", 8'h15, {3'h0, scan_data.marker_blink});
    // Blank the next cell through the load option, then mark it to blink.
    put(REG_COMMAND, 8'h41);
    put(REG_COMMAND, 8'h8a);
    put(REG_COMMAND, 8'he1);
    put(REG_COMMAND, 8'h02);
    scan(6'h21, 8'h20);
    chk8("scan_char_blink", 8'h01, {7'h00, scan_data.char_blink});
    rchk("pointer_char", REG_POINTER, 8'h22);
    @(posedge clock);
    serial_mode <= 1'b1;
    foreach (setup_cmds[i]) put(REG_COMMAND, setup_cmds[i]);
    rchk("mode_on", REG_MODE, 8'h17);
    chk8("so_oe", 8'h01, {7'h00, so_oe});
    put(REG_COMMAND, 8'h84);
    rchk("status_standby", REG_STATUS, 8'h02);
    rchk("mode_standby", REG_MODE, 8'h11);
    rchk("pointer_standby", REG_POINTER, 8'h00);
    rchk("setup_standby", REG_SETUP, 8'h47);
    scan(6'h0b, 8'h41);
    put(REG_COMMAND, 8'h89);
    rchk("status_wake", REG_STATUS, 8'h00);
    rchk("mode_wake", REG_MODE, 8'h13);
    repeat (5) put(REG_COMMAND, 8'h83);
    rchk("contrast_top", REG_SETUP, 8'he7);
    put(REG_COMMAND, 8'h83);
    rchk("contrast_wrap", REG_SETUP, 8'h07);
    // Second reset: memory survives, timing restarts from zero.
    @(posedge clock);
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t0 = ticks;
    scan(6'h0b, 8'h41);
    rchk("setup_reset", REG_SETUP, 8'h00);
    wpulse(ta);
    wpulse(tb);
    chkn("frame16", 448, tb - ta);
    duty_nine <= 1'b1;
    wpulse(ta);
    wpulse(ta);
    wpulse(tb);
    chkn("frame9", 468, tb - ta);
    n = 0;
    while (blink_phase !== 1'b1 && n < 80000) begin
      @(posedge clock);
      n++;
    end
    chkn("blink_half", 1, int'(ticks - t0 >= 16380 && ticks - t0 <= 16390));
    summarize();
  end
endmodule // testbench
`default_nettype wire
